/* File: hdl/serial_link_self_test_pkg.sv */
// Shared constants and types for the serial link self-test checker
package serial_link_self_test_pkg;

    // Payload bits carried by one received frame
    localparam int unsigned FRAME_BITS = 35;

    // Expected payload during self test: all zeros
    localparam logic [FRAME_BITS-1:0] EXPECTED_PAYLOAD = 35'h0_0000_0000;

    // Default length of the error pulse on the result output, in clock cycles
    localparam int unsigned ERROR_PULSE_CYCLES = 1;
    localparam int unsigned PULSE_CNT_BITS     = 8;

    // Levels driven on the result and clock-source outputs
    localparam logic RESULT_PASS  = 1'b1;
    localparam logic RESULT_FAIL  = 1'b0;
    localparam logic SRC_PIXEL    = 1'b0;
    localparam logic SRC_OSC      = 1'b1;

    typedef enum logic [1:0] {
        ST_IDLE      = 2'b00,
        ST_WAIT_LOCK = 2'b01,
        ST_CHECK     = 2'b10,
        ST_HOLD      = 2'b11
    } test_state_t;

endpackage : serial_link_self_test_pkg

/* File: hdl/serial_link_self_test_checker.sv */
// Receive-side self-test controller and checker for the serial link
`timescale 1ns/10ps
// What this block does
// - Pin or config bit enters self-test mode
// - Oscillator selectable when pixel clock absent
// - Activation sends enable over back channel
// - Flag every received frame containing errors
// - Each error drives result low briefly
// - Hold last outcome until new test or reset
// - Held result high if clean, low if errors
// - Run length equals enable hold time
// - Lock status stays valid during test
// - On lock drive result high, start checking
// - Compare payload against all zeros
module serial_link_self_test_checker #(
    parameter int unsigned FRAME_BITS  = serial_link_self_test_pkg::FRAME_BITS,
    parameter int unsigned PULSE_CYCLES = serial_link_self_test_pkg::ERROR_PULSE_CYCLES
) (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic                  selfTestEnablePin,
    input  wire logic                  selfTestEnableCfg,
    input  wire logic                  selfTestClockSelectPin,
    input  wire logic                  selfTestClockSelectCfg,
    input  wire logic                  pixelClockPresent,
    input  wire logic                  linkLocked,
    input  wire logic                  frameValid,
    input  wire logic [FRAME_BITS-1:0] framePayload,
    output logic                       testResultOutput,
    output logic                       backChannelTestEnable,
    output logic                       testClockUsesOsc,
    output logic                       lockStatus,
    output logic                       testActive
);

    // Run sequencing state
    serial_link_self_test_pkg::test_state_t               state_r;
    serial_link_self_test_pkg::test_state_t               state_nxt;
    logic                                            errorSeen_r;
    logic                                            errorSeen_nxt;
    logic                                            active_r;
    logic                                            active_nxt;
    // Result pin state
    logic [serial_link_self_test_pkg::PULSE_CNT_BITS-1:0] pulseCnt_r;
    logic [serial_link_self_test_pkg::PULSE_CNT_BITS-1:0] pulseCnt_nxt;
    logic                                            result_r;
    logic                                            result_nxt;
    // Back-channel request, clock choice and lock echo
    logic                                            bcEnable_r;
    logic                                            bcEnable_nxt;
    logic                                            useOsc_r;
    logic                                            useOsc_nxt;
    logic                                            lock_r;
    logic                                            lock_nxt;
    // Decoded requests
    logic                                            enable;
    logic                                            oscRequest;
    logic                                            runStart;
    logic                                            frameBad;
    logic                                            pulseActive;

    localparam logic [serial_link_self_test_pkg::PULSE_CNT_BITS-1:0] PULSE_LOAD =
        serial_link_self_test_pkg::PULSE_CNT_BITS'(PULSE_CYCLES);
    localparam logic [serial_link_self_test_pkg::PULSE_CNT_BITS-1:0] PULSE_ZERO =
        serial_link_self_test_pkg::PULSE_CNT_BITS'(0);
    localparam logic [serial_link_self_test_pkg::PULSE_CNT_BITS-1:0] PULSE_ONE =
        serial_link_self_test_pkg::PULSE_CNT_BITS'(1);
    localparam logic [FRAME_BITS-1:0] EXPECTED =
        FRAME_BITS'(serial_link_self_test_pkg::EXPECTED_PAYLOAD);

    // Requests and frame status seen this cycle
    always_comb begin
        enable      = selfTestEnablePin | selfTestEnableCfg;
        // The oscillator may only be chosen while the pixel clock is missing
        oscRequest  = (selfTestClockSelectPin | selfTestClockSelectCfg) && !pixelClockPresent;
        runStart    = enable && ((state_r == serial_link_self_test_pkg::ST_IDLE)
                                 || (state_r == serial_link_self_test_pkg::ST_HOLD));
        frameBad    = frameValid && (framePayload != EXPECTED);
        pulseActive = pulseCnt_r > PULSE_ONE;
    end

    // Run sequencing: idle, wait for lock, check frames, hold the outcome
    always_comb begin
        state_nxt     = state_r;
        errorSeen_nxt = errorSeen_r;
        active_nxt    = 1'b0;
        case (state_r)
            serial_link_self_test_pkg::ST_IDLE, serial_link_self_test_pkg::ST_HOLD: begin
                if (enable) begin
                    state_nxt     = serial_link_self_test_pkg::ST_WAIT_LOCK;
                    errorSeen_nxt = 1'b0;
                    active_nxt    = 1'b1;
                end
            end
            serial_link_self_test_pkg::ST_WAIT_LOCK: begin
                if (!enable) begin
                    state_nxt = serial_link_self_test_pkg::ST_HOLD;
                end else if (linkLocked) begin
                    state_nxt  = serial_link_self_test_pkg::ST_CHECK;
                    active_nxt = 1'b1;
                end else begin
                    active_nxt = 1'b1;
                end
            end
            serial_link_self_test_pkg::ST_CHECK: begin
                // Frames are judged only here; frames before lock are ignored
                if (!enable) begin
                    state_nxt = serial_link_self_test_pkg::ST_HOLD;
                end else begin
                    active_nxt = 1'b1;
                    if (frameBad) begin
                        errorSeen_nxt = 1'b1;
                    end
                end
            end
            default: begin
                state_nxt = serial_link_self_test_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r     <= serial_link_self_test_pkg::ST_IDLE;
            errorSeen_r <= 1'b0;
            active_r    <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            errorSeen_r <= errorSeen_nxt;
            active_r    <= active_nxt;
        end
    end

    // Result pin: high while clean, low pulse per bad frame, then the held verdict
    always_comb begin
        pulseCnt_nxt = pulseCnt_r;
        result_nxt   = result_r;
        case (state_r)
            serial_link_self_test_pkg::ST_IDLE, serial_link_self_test_pkg::ST_HOLD: begin
                if (enable) begin
                    pulseCnt_nxt = PULSE_ZERO;
                end
            end
            serial_link_self_test_pkg::ST_WAIT_LOCK: begin
                // A run that never locked checked no frames and holds a pass
                if (!enable || linkLocked) begin
                    result_nxt = serial_link_self_test_pkg::RESULT_PASS;
                end
            end
            serial_link_self_test_pkg::ST_CHECK: begin
                if (!enable) begin
                    pulseCnt_nxt = PULSE_ZERO;
                    result_nxt   = errorSeen_r ? serial_link_self_test_pkg::RESULT_FAIL
                                               : serial_link_self_test_pkg::RESULT_PASS;
                end else if (frameBad) begin
                    // A new bad frame restarts the low pulse
                    pulseCnt_nxt = PULSE_LOAD;
                    result_nxt   = serial_link_self_test_pkg::RESULT_FAIL;
                end else if (pulseActive) begin
                    pulseCnt_nxt = pulseCnt_r - PULSE_ONE;
                end else begin
                    pulseCnt_nxt = PULSE_ZERO;
                    result_nxt   = serial_link_self_test_pkg::RESULT_PASS;
                end
            end
            default: begin
                pulseCnt_nxt = PULSE_ZERO;
                result_nxt   = serial_link_self_test_pkg::RESULT_PASS;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        // Reset shows a pass on the result pin
        if (rst) begin
            pulseCnt_r <= PULSE_ZERO;
            result_r   <= serial_link_self_test_pkg::RESULT_PASS;
        end else begin
            pulseCnt_r <= pulseCnt_nxt;
            result_r   <= result_nxt;
        end
    end

    // Back-channel request, test clock choice and lock echo
    always_comb begin
        bcEnable_nxt = enable;
        lock_nxt     = linkLocked;
        useOsc_nxt   = useOsc_r;
        // The clock choice follows the pins until a run starts, then stays fixed
        if (!enable || runStart) begin
            useOsc_nxt = oscRequest ? serial_link_self_test_pkg::SRC_OSC
                                    : serial_link_self_test_pkg::SRC_PIXEL;
        end
    end

    always_ff @(posedge mclk) begin
        // Lock echo keeps updating through every run
        if (rst) begin
            bcEnable_r <= 1'b0;
            useOsc_r   <= serial_link_self_test_pkg::SRC_PIXEL;
            lock_r     <= 1'b0;
        end else begin
            bcEnable_r <= bcEnable_nxt;
            useOsc_r   <= useOsc_nxt;
            lock_r     <= lock_nxt;
        end
    end

    // Outputs come straight from the registers
    always_comb begin
        testResultOutput      = result_r;
        backChannelTestEnable = bcEnable_r;
        testClockUsesOsc      = useOsc_r;
        lockStatus            = lock_r;
        testActive            = active_r;
    end

endmodule : serial_link_self_test_checker

/* File: verif/serial_link_self_test_checker_monitor.sv */
// Port assertions for the self-test checker
`timescale 1ns/10ps
module serial_link_self_test_checker_monitor #(
    parameter int unsigned FRAME_BITS   = 35,
    parameter int unsigned PULSE_CYCLES = 1
) (
    input wire logic                  mclk,
    input wire logic                  rst,
    input wire logic                  selfTestEnablePin,
    input wire logic                  selfTestEnableCfg,
    input wire logic                  selfTestClockSelectPin,
    input wire logic                  selfTestClockSelectCfg,
    input wire logic                  pixelClockPresent,
    input wire logic                  linkLocked,
    input wire logic                  frameValid,
    input wire logic [FRAME_BITS-1:0] framePayload,
    input wire logic                  testResultOutput,
    input wire logic                  backChannelTestEnable,
    input wire logic                  testClockUsesOsc,
    input wire logic                  lockStatus,
    input wire logic                  testActive
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire  en     = selfTestEnablePin | selfTestEnableCfg;
    wire  oscReq = (selfTestClockSelectPin | selfTestClockSelectCfg) & ~pixelClockPresent;
    logic inCheck_r;
    logic errSeen_r;
    wire  bad    = en & inCheck_r & frameValid & (framePayload != '0);
    // Checking phase: run active and enabled, entered once lock is seen
    always_ff @(posedge mclk) begin
        inCheck_r <= !rst && en && testActive && (inCheck_r || linkLocked);
        errSeen_r <= (rst || (en && !testActive)) ? 1'b0 : (errSeen_r | bad);
    end
    a_run_start: assert property (en |=> backChannelTestEnable && testActive)
        else $error("run did not start");
    a_run_stop: assert property (!en |=> !backChannelTestEnable && !testActive)
        else $error("run did not stop");
    a_lock_track: assert property (1 |=> lockStatus == $past(linkLocked))
        else $error("lock status stale");
    a_osc_select: assert property (en && !testActive |=> testClockUsesOsc == $past(oscReq))
        else $error("wrong test clock source");
    a_err_low: assert property (bad |=> !testResultOutput)
        else $error("bad frame not flagged");
    a_pulse_end: assert property (bad ##1 (en && !bad) |=> testResultOutput)
        else $error("error pulse too long");
    a_osc_latch: assert property (testActive && en |=> $stable(testClockUsesOsc))
        else $error("test clock changed in run");
    a_lock_pass: assert property (testActive && en && linkLocked && !inCheck_r |=> testResultOutput)
        else $error("result not high on lock");
    a_hold_value: assert property ($fell(testActive) |-> testResultOutput == !errSeen_r)
        else $error("wrong held result");
    a_hold_stable: assert property (!en && !testActive && !$fell(testActive) |-> $stable(testResultOutput))
        else $error("held result changed");
    cover property (bad);
    cover property ($fell(testActive) && !testResultOutput);
    cover property ($fell(testActive) && testResultOutput);
endmodule : serial_link_self_test_checker_monitor

/* File: verif/serializer_model.sv */
// Remote serializer: locks after enable, sends frames with optional payload errors
`timescale 1ns/10ps
module serializer_model (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        bcEnable,
    input  wire logic        useOsc,
    input  wire logic [3:0]  straps,
    input  wire logic [34:0] errMask,
    output logic             linkLocked,
    output logic             frameValid,
    output logic [34:0]      framePayload,
    output logic [7:0]       crcErrs
);
    int   cnt    = 0;
    logic bcPrev = 1'b0;
    // Frames every second cycle on the pixel clock, every third on the oscillator
    wire  slot   = useOsc ? (cnt % 3 == 0) : cnt[0];
    wire  nv     = !rst && bcEnable && linkLocked && slot;
    always @(posedge mclk) begin
        cnt          <= (rst || !bcEnable) ? 0 : cnt + 1;
        linkLocked   <= !rst && bcEnable && cnt >= 2 && straps == 4'h1;
        frameValid   <= nv;
        framePayload <= nv ? errMask : ~framePayload;
        bcPrev       <= bcEnable;
        // Back-channel check: an unresolved enable counts as a CRC error
        if (rst || (bcEnable && !bcPrev)) begin
            crcErrs <= 8'h00;
        end else if (^bcEnable === 1'bx) begin
            crcErrs <= crcErrs + 8'h01;
        end
    end
endmodule : serializer_model

/* File: verif/tb.sv */
// Self-checking bench for the self-test checker
`timescale 1ns/10ps
`define CHK(n, e, s) begin totalChecks++; if ((s) !== (e)) begin errCount++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb;
    logic mclk, rst, pin, cfg, selPin, selCfg, pixOk;
    logic [34:0] errMask, payload;
    logic lnk, fv, res, bc, osc, lockSt, act;
    logic [3:0] straps;
    logic [7:0] crc;
    int errCount = 0, totalChecks = 0, st = 0, errs = 0, seed = 32'h576095a2;
    logic expRes = 1, expOsc = 0, enD = 0, lockD = 0;
    serial_link_self_test_checker #(.PULSE_CYCLES(1)) dut (.mclk(mclk), .rst(rst),
        .selfTestEnablePin(pin), .selfTestEnableCfg(cfg), .selfTestClockSelectPin(selPin),
        .selfTestClockSelectCfg(selCfg), .pixelClockPresent(pixOk), .linkLocked(lnk),
        .frameValid(fv), .framePayload(payload), .testResultOutput(res),
        .backChannelTestEnable(bc), .testClockUsesOsc(osc), .lockStatus(lockSt), .testActive(act));
    serializer_model far (.mclk(mclk), .rst(rst), .bcEnable(bc), .useOsc(osc), .straps(straps),
        .errMask(errMask), .linkLocked(lnk), .frameValid(fv), .framePayload(payload),
        .crcErrs(crc));
    initial begin
        mclk = 0;
        forever #4 mclk = ~mclk;
    end
    // Reference model of the checker state
    always @(posedge mclk) begin
        enD = rst ? 1'b0 : (pin | cfg);
        lockD = rst ? 1'b0 : lnk;
        if (rst) begin
            st = 0;
            errs = 0;
            expRes = 1;
        end else if (enD && (st == 0 || st == 3)) begin
            st = 1;
            errs = 0;
            expOsc = (selPin | selCfg) & ~pixOk;
        end else if (!enD && st inside {1, 2}) begin
            st = 3;
            expRes = (errs == 0);
        end else if (st == 1 && lnk) begin
            st = 2;
            expRes = 1;
        end else if (st == 2) begin
            expRes = !(fv && payload != '0);
            errs += !expRes;
        end
    end
    always @(negedge mclk) begin
        if (st != 1) `CHK("result", expRes, res)
        `CHK("bcEnable", enD, bc)
        `CHK("active", st == 1 || st == 2, act)
        `CHK("lock", lockD, lockSt)
        if (st inside {1, 2}) `CHK("osc", expOsc, osc)
    end
    task automatic run(input logic p, sp, sc, px, input int len, rate);
        selPin <= sp;
        selCfg <= sc;
        pixOk  <= px;
        @(posedge mclk);
        if (p) begin
            pin <= 1;
        end else begin
            cfg <= 1;
        end
        repeat (len) begin
            @(posedge mclk);
            errMask <= ($unsigned($random(seed)) % 4 < rate) ? 35'({$random(seed), $random(seed)}) : '0;
        end
        @(posedge mclk);
        {pin, cfg, errMask} <= '0;
        repeat (6) @(posedge mclk);
        `CHK("crcErrs", 8'h00, crc)
    endtask : run
    task tallyAndFinish;
        $display("checks %0d errors %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tallyAndFinish
    initial begin
        {pin, cfg, selPin, selCfg, errMask} = '0;
        pixOk = 1;
        straps = 4'h1;
        rst = 1;
        repeat (4) @(posedge mclk);
        rst <= 0;
        run(1, 0, 1, 0, 20, 0);
        run(0, 1, 0, 1, 40, 2);
        run(1, 1, 1, 0, 25, 0);
        run(1, 0, 0, 1, 1, 0);
        // Reset in the middle of a run with a bad payload
        pin <= 1;
        errMask <= 35'h4;
        repeat (12) @(posedge mclk);
        rst <= 1;
        pin <= 0;
        repeat (3) @(posedge mclk);
        rst <= 0;
        errMask <= '0;
        repeat (4) @(posedge mclk);
        tallyAndFinish();
    end
    initial begin
        repeat (2000) @(posedge mclk);
        errCount++;
        tallyAndFinish();
    end
endmodule : tb
bind serial_link_self_test_checker serial_link_self_test_checker_monitor #(
    .FRAME_BITS   (FRAME_BITS),
    .PULSE_CYCLES (PULSE_CYCLES)
) mon (
    .mclk                   (mclk),
    .rst                    (rst),
    .selfTestEnablePin      (selfTestEnablePin),
    .selfTestEnableCfg      (selfTestEnableCfg),
    .selfTestClockSelectPin (selfTestClockSelectPin),
    .selfTestClockSelectCfg (selfTestClockSelectCfg),
    .pixelClockPresent      (pixelClockPresent),
    .linkLocked             (linkLocked),
    .frameValid             (frameValid),
    .framePayload           (framePayload),
    .testResultOutput       (testResultOutput),
    .backChannelTestEnable  (backChannelTestEnable),
    .testClockUsesOsc       (testClockUsesOsc),
    .lockStatus             (lockStatus),
    .testActive             (testActive)
);
